// file: hw/dscr_regs.v
`include "dscr_defines.vh"
// How it works
// [RULE1] A rising bit 0 of the run command word pulses a stop command.
// [RULE2] A rising bit 1 of the run command word pulses a forward run command.
// [RULE3] A rising bit 2 of the run command word pulses a reverse run command.
// [RULE4] Status bits 6,7,8,10 show arrival, DC braking, stopping, brake open; bit 9 zero.
// [RULE5] Status bits 11 and 12 show active forward and reverse run commands.
// [RULE6] Status bits 13 and 14 show remote run source and remote speed source.
// [RULE7] Trip word bit 6 flags an earth leakage trip.
// [RULE8] Trip word flags heatsink overheat (bit 6) and motor thermal trip (bit 7).
// [RULE9] Trip word bit 8 flags load excess; bits 5 and 11 read zero.
// [RULE10] Trip bits 13,14 plugin error, phase loss; 10,12,15 diagnostic, current classes.
// [RULE11] Rising bit 3 resets a fault; rising bit 4 issues an emergency stop.
// [RULE12] Run command bits 7:6 read back the command source code.
// [RULE13] Run command bit 15 is a read-only network malfunction flag.
// [RULE14] Writes to read-only words change nothing and trigger no action.
// [RULE15] Command bits act only on a rising transition, never on level or zero.
module dscr_regs (
	input  wire        clk,
	input  wire        rstn,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [15:0] reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output reg         reg_ack,
	output reg         reg_err,
	output reg         cmd_stop,
	output reg         cmd_fwd,
	output reg         cmd_rev,
	output reg         cmd_fault_reset,
	output reg         cmd_estop,
	input  wire [1:0]  cmd_source,
	input  wire        net_error,
	input  wire        speed_arrived,
	input  wire        dc_braking,
	input  wire        stopping,
	input  wire        brake_open,
	input  wire        fwd_run_active,
	input  wire        rev_run_active,
	input  wire        remote_speed_source,
	input  wire [15:0] base_status,
	input  wire        earth_leak_trip,
	input  wire        drive_heatsink_trip,
	input  wire        motor_thermal_trip,
	input  wire        load_excess_trip,
	input  wire        hardware_diagnostic_trip,
	input  wire        second_current_trip,
	input  wire        plugin_board_error,
	input  wire        input_phase_loss,
	input  wire        inverter_load_trip,
	input  wire [4:0]  base_trips,
	input  wire [15:0] input_terminal_states,
	input  wire [15:0] output_terminal_states,
	input  wire [15:0] analog_voltage_in_one,
	input  wire [15:0] analog_voltage_in_two,
	input  wire [15:0] analog_current_in,
	input  wire [15:0] shaft_speed,
	input  wire [15:0] display_unit_select,
	input  wire [15:0] motor_pole_count,
	input  wire [15:0] custom_build_version
);
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function is_mapped;
		input [15:0] a;
		begin
			case (a)
			`DSCR_ADDR_RUN_CMD, `DSCR_ADDR_OP_STATUS, `DSCR_ADDR_TRIP,
			`DSCR_ADDR_IN_TERM, `DSCR_ADDR_OUT_TERM, `DSCR_ADDR_AIN_V1,
			`DSCR_ADDR_AIN_V2, `DSCR_ADDR_AIN_I, `DSCR_ADDR_SPEED,
			`DSCR_ADDR_UNIT_SEL, `DSCR_ADDR_POLES, `DSCR_ADDR_CUST_VER: begin
				is_mapped = 1'b1;
			end
			default: begin
				is_mapped = 1'b0;
			end
			endcase
		end
	endfunction

	// ----------------------------------------
	// Status input synchronisers
	// ----------------------------------------
	// Flags from the drive core come from another domain, so all pass two flops.
	wire [15:0] ops_raw;
	wire [15:0] trip_raw;
	wire [15:0] ops_s;
	wire [15:0] trip_s;
	wire [15:0] misc_s;
	wire [2:0]  cmdsrc_s;
	wire [1:0]  src_s;
	wire        neterr_s;

	assign ops_raw = {1'b0, remote_speed_source, 1'b0, rev_run_active, fwd_run_active,
		brake_open, 1'b0, stopping, dc_braking, speed_arrived, base_status[5:0]};
	assign trip_raw = {inverter_load_trip, input_phase_loss, plugin_board_error,
		second_current_trip, 1'b0, hardware_diagnostic_trip, 1'b0, load_excess_trip,
		motor_thermal_trip, earth_leak_trip | drive_heatsink_trip, 1'b0, base_trips};

	dscr_sync #(.W(16)) u_sync_ops (
		.clk  (clk),
		.rstn (rstn),
		.d    (ops_raw),
		.q    (ops_s)
	);
	dscr_sync #(.W(16)) u_sync_trip (
		.clk  (clk),
		.rstn (rstn),
		.d    (trip_raw),
		.q    (trip_s)
	);
	dscr_sync #(.W(16)) u_sync_misc (
		.clk  (clk),
		.rstn (rstn),
		.d    ({13'h0000, net_error, cmd_source}),
		.q    (misc_s)
	);
	assign src_s    = misc_s[1:0];
	assign neterr_s = misc_s[2];
	assign cmdsrc_s = {neterr_s, src_s};

	// ----------------------------------------
	// Status word assembly
	// ----------------------------------------
	reg  [15:0] ops_word;
	reg  [15:0] trip_word;
	wire        remote_run_source;

	assign remote_run_source = (src_s == `DSCR_SRC_SERIAL) || (src_s == `DSCR_SRC_OPTION);

	always @* begin
		ops_word = ops_s;
		ops_word[9] = 1'b0; // [RULE4]
		ops_word[`DSCR_OPS_FWDCMD_BIT] = ops_s[`DSCR_OPS_FWDCMD_BIT]; // [RULE5]
		ops_word[`DSCR_OPS_REVCMD_BIT] = ops_s[`DSCR_OPS_REVCMD_BIT]; // [RULE5]
		ops_word[`DSCR_OPS_REMRS_BIT]  = remote_run_source; // [RULE6]
		ops_word[15] = 1'b0;
	end

	// Heatsink and earth leakage share bit 6; they are OR-ed because the position is doubtful.
	always @* begin
		trip_word = trip_s & ~`DSCR_TRIP_RSVD_MASK; // [RULE9]
		trip_word[`DSCR_TRIP_EARTH_BIT] = trip_s[6]; // [RULE7] [RULE8]
		trip_word[`DSCR_TRIP_MOTOR_BIT] = trip_s[7]; // [RULE8]
		trip_word[`DSCR_TRIP_LOAD_BIT]  = trip_s[8]; // [RULE9]
		trip_word[`DSCR_TRIP_PLUGIN_BIT] = trip_s[13]; // [RULE10]
		trip_word[`DSCR_TRIP_PHASE_BIT]  = trip_s[14]; // [RULE10]
	end

	// ----------------------------------------
	// Run command word
	// ----------------------------------------
	reg  [4:0]  run_cmd_q;
	wire [4:0]  cmd_rise;
	wire        wr_run;

	assign wr_run = reg_wr && (reg_addr == `DSCR_ADDR_RUN_CMD);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_cmd_q <= 5'h00;
		end else if (wr_run) begin
			run_cmd_q <= reg_wdata[4:0];
		end
	end

	dscr_rise_det #(.W(5)) u_rise (
		.clk  (clk),
		.rstn (rstn),
		.lvl  (run_cmd_q),
		.rise (cmd_rise)
	);

	// Pulses are registered so each command is a clean one-cycle strobe.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_stop        <= 1'b0;
			cmd_fwd         <= 1'b0;
			cmd_rev         <= 1'b0;
			cmd_fault_reset <= 1'b0;
			cmd_estop       <= 1'b0;
		end else begin
			cmd_stop        <= cmd_rise[`DSCR_CMD_STOP_BIT]; // [RULE1]
			cmd_fwd         <= cmd_rise[`DSCR_CMD_FWD_BIT]; // [RULE2]
			cmd_rev         <= cmd_rise[`DSCR_CMD_REV_BIT]; // [RULE3]
			cmd_fault_reset <= cmd_rise[`DSCR_CMD_FRST_BIT]; // [RULE11]
			cmd_estop       <= cmd_rise[`DSCR_CMD_ESTOP_BIT]; // [RULE11]
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [15:0] rd_mux;
	always @* begin
		case (reg_addr)
		`DSCR_ADDR_RUN_CMD: begin
			rd_mux = {cmdsrc_s[2], 7'h00, src_s, 1'b0, run_cmd_q}; // [RULE12] [RULE13]
		end
		`DSCR_ADDR_OP_STATUS: begin
			rd_mux = ops_word;
		end
		`DSCR_ADDR_TRIP: begin
			rd_mux = trip_word;
		end
		`DSCR_ADDR_IN_TERM: begin
			rd_mux = input_terminal_states;
		end
		`DSCR_ADDR_OUT_TERM: begin
			rd_mux = output_terminal_states;
		end
		`DSCR_ADDR_AIN_V1: begin
			rd_mux = analog_voltage_in_one;
		end
		`DSCR_ADDR_AIN_V2: begin
			rd_mux = analog_voltage_in_two;
		end
		`DSCR_ADDR_AIN_I: begin
			rd_mux = analog_current_in;
		end
		`DSCR_ADDR_SPEED: begin
			rd_mux = shaft_speed;
		end
		`DSCR_ADDR_UNIT_SEL: begin
			rd_mux = display_unit_select;
		end
		`DSCR_ADDR_POLES: begin
			rd_mux = motor_pole_count;
		end
		`DSCR_ADDR_CUST_VER: begin
			rd_mux = custom_build_version;
		end
		default: begin
			rd_mux = 16'h0000;
		end
		endcase
	end

	// Writes to read-only words are acknowledged but store nothing.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
			reg_ack   <= 1'b0;
			reg_err   <= 1'b0;
		end else begin
			reg_ack <= reg_wr | reg_rd; // [RULE14]
			reg_err <= (reg_wr | reg_rd) & ~is_mapped(reg_addr);
			if (reg_rd) begin
				reg_rdata <= rd_mux;
			end
		end
	end
endmodule // dscr_regs

// file: hw/dscr_defines.vh
`ifndef DSCR_DEFINES_VH
`define DSCR_DEFINES_VH
// ----------------------------------------
// Register indices (word addresses)
// ----------------------------------------
`define DSCR_ADDR_RUN_CMD    16'h0006
`define DSCR_ADDR_OP_STATUS  16'h000E
`define DSCR_ADDR_TRIP       16'h000F
`define DSCR_ADDR_IN_TERM    16'h0010
`define DSCR_ADDR_OUT_TERM   16'h0011
`define DSCR_ADDR_AIN_V1     16'h0012
`define DSCR_ADDR_AIN_V2     16'h0013
`define DSCR_ADDR_AIN_I      16'h0014
`define DSCR_ADDR_SPEED      16'h0015
`define DSCR_ADDR_UNIT_SEL   16'h001A
`define DSCR_ADDR_POLES      16'h001B
`define DSCR_ADDR_CUST_VER   16'h001C
// ----------------------------------------
// Run command word fields
// ----------------------------------------
`define DSCR_CMD_STOP_BIT    0
`define DSCR_CMD_FWD_BIT     1
`define DSCR_CMD_REV_BIT     2
`define DSCR_CMD_FRST_BIT    3
`define DSCR_CMD_ESTOP_BIT   4
`define DSCR_CMD_SRC_LSB     6
`define DSCR_CMD_NETERR_BIT  15
`define DSCR_CMD_WR_MASK     16'h001F
`define DSCR_RUN_CMD_RESET   16'h0000
// ----------------------------------------
// Operating status word fields
// ----------------------------------------
`define DSCR_OPS_ARRIVE_BIT  6
`define DSCR_OPS_DCBRK_BIT   7
`define DSCR_OPS_STOPPING_BIT 8
`define DSCR_OPS_BRKOPEN_BIT 10
`define DSCR_OPS_FWDCMD_BIT  11
`define DSCR_OPS_REVCMD_BIT  12
`define DSCR_OPS_REMRS_BIT   13
`define DSCR_OPS_REMFQ_BIT   14
// ----------------------------------------
// Trip word fields
// ----------------------------------------
`define DSCR_TRIP_EARTH_BIT  6
`define DSCR_TRIP_HSINK_BIT  6
`define DSCR_TRIP_MOTOR_BIT  7
`define DSCR_TRIP_LOAD_BIT   8
`define DSCR_TRIP_HWDIAG_BIT 10
`define DSCR_TRIP_OC2_BIT    12
`define DSCR_TRIP_PLUGIN_BIT 13
`define DSCR_TRIP_PHASE_BIT  14
`define DSCR_TRIP_INVLD_BIT  15
`define DSCR_TRIP_RSVD_MASK  16'h0820
`define DSCR_SRC_SERIAL      2'h3
`define DSCR_SRC_OPTION      2'h2
`endif

// file: hw/dscr_rise_det.v
`include "dscr_defines.vh"
// ----------------------------------------
// Rising edge detector, one pulse per 0 to 1 step.
// ----------------------------------------
module dscr_rise_det #(
	parameter W = 5
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire [W-1:0] lvl,
	output wire [W-1:0] rise
);
	reg [W-1:0] prev_q;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_q <= {W{1'b0}};
		end else begin
			prev_q <= lvl;
		end
	end
	// Holding a bit high gives no further pulse.
	assign rise = lvl & ~prev_q; // [RULE15]
endmodule // dscr_rise_det

// file: hw/dscr_sync.v
`include "dscr_defines.vh"
// ----------------------------------------
// Two-stage synchroniser for pin-level status inputs.
// ----------------------------------------
module dscr_sync #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_q;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= {W{1'b0}};
			q      <= {W{1'b0}};
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // dscr_sync

// file: testbench/dscr_regs_monitor.sv
// --------
// Checker
// --------
module dscr_regs_monitor (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_ack,
	input wire logic        reg_err,
	input wire logic        cmd_stop,
	input wire logic        cmd_fwd,
	input wire logic        cmd_rev,
	input wire logic        cmd_fault_reset,
	input wire logic        cmd_estop
);
	timeunit 1ns;
	timeprecision 1ps;
	reg  [4:0] wr_q;
	wire       run_wr = reg_wr && reg_addr == 16'h0006;
	wire [4:0] rise   = reg_wdata[4:0] & ~wr_q;
	wire [4:0] cmd_v  = {cmd_estop, cmd_fault_reset, cmd_rev, cmd_fwd, cmd_stop};
	// Shadow of the written command bits, so a rise is judged against the last write.
	// The rise is taken from the write edge, since the bus has moved on by the pulse.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= 5'h00;
		end else if (run_wr) begin
			wr_q <= reg_wdata[4:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_stop_pulse: assert property (
		run_wr |-> ##2 cmd_stop == $past(rise[0], 2))
		else $error("stop pulse wrong");
	a_fwd_pulse: assert property (
		run_wr |-> ##2 cmd_fwd == $past(rise[1], 2))
		else $error("forward pulse wrong");
	a_rev_pulse: assert property (
		run_wr |-> ##2 cmd_rev == $past(rise[2], 2))
		else $error("reverse pulse wrong");
	a_reset_estop: assert property (
		run_wr |-> ##2 cmd_v[4:3] == $past(rise[4:3], 2))
		else $error("reset or estop pulse wrong");
	a_no_spurious: assert property (!run_wr |-> ##2 cmd_v == 5'h00)
		else $error("command without write");
	a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
		else $error("missing ack");
	a_ack_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
		else $error("ack without request");
	a_trip_rsvd: assert property (
		reg_rd && reg_addr == 16'h000F |=> (reg_rdata & 16'h0820) == 16'h0000)
		else $error("reserved trip bits set");
	a_stat_unused: assert property (
		reg_rd && reg_addr == 16'h000E |=> !reg_rdata[9])
		else $error("status bit 9 set");
	a_run_unused: assert property (
		reg_rd && reg_addr == 16'h0006 |=> reg_rdata[14:8] == 7'h00)
		else $error("run word unused bits set");
	a_rdata_hold: assert property (!(reg_rd || reg_wr) |=> $stable(reg_rdata))
		else $error("read data moved");
	cover property (run_wr && rise != 5'h00);
	cover property (reg_ack && reg_err);
	cover property (reg_rd && reg_addr == 16'h000F);
endmodule // dscr_regs_monitor
bind dscr_regs dscr_regs_monitor mon (.*);

// file: testbench/dscr_link_master.sv
// --------
// Link master model
// --------
module dscr_link_master (
	input  wire logic        clk,
	output logic        reg_wr,
	output logic        reg_rd,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_ack,
	input  wire logic        reg_err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rdata_s;
	logic        ack_s;
	logic        err_s;
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata} = 34'h0;
	end
	// Idle address and data show the inverse, so nothing can lean on stale values.
	task automatic xfer(input logic w, input logic [15:0] a, d);
		@(negedge clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
		@(negedge clk);
		{rdata_s, ack_s, err_s} = {reg_rdata, reg_ack, reg_err};
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
	endtask
endmodule // dscr_link_master

// file: testbench/dscr_regs_tb.sv
// --------
// Testbench
// --------
module dscr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        reg_wr, reg_rd, reg_ack, reg_err;
	logic [15:0] reg_addr, reg_wdata, reg_rdata;
	logic        cmd_stop, cmd_fwd, cmd_rev, cmd_fault_reset, cmd_estop;
	logic [1:0]  cmd_source;
	logic        net_error, speed_arrived, dc_braking, stopping, brake_open;
	logic        fwd_run_active, rev_run_active, remote_speed_source;
	logic [15:0] base_status;
	logic        earth_leak_trip, drive_heatsink_trip, motor_thermal_trip, load_excess_trip;
	logic        hardware_diagnostic_trip, second_current_trip, plugin_board_error;
	logic        input_phase_loss, inverter_load_trip;
	logic [4:0]  base_trips;
	logic [15:0] input_terminal_states, output_terminal_states, analog_voltage_in_one;
	logic [15:0] analog_voltage_in_two, analog_current_in, shaft_speed;
	logic [15:0] display_unit_select, motor_pole_count, custom_build_version;
	wire  [4:0]  cmd_v = {cmd_estop, cmd_fault_reset, cmd_rev, cmd_fwd, cmd_stop};
	int          bad_count = 0;
	int          check_count = 0;
	always #2.5 clk = ~clk;
	dscr_regs        uut (.*);
	dscr_link_master m (.*);
	task automatic chk(input string n, input logic [15:0] e, s);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic io(input logic w, input logic [15:0] a, d, input logic er);
		m.xfer(w, a, d);
		chk("ack", 16'h0001, {15'h0000, m.ack_s});
		chk("err", {15'h0000, er}, {15'h0000, m.err_s});
	endtask
	task automatic rd(input logic [15:0] a, e);
		io(1'b0, a, 16'h0000, 1'b0);
		chk("rdata", e, m.rdata_s);
	endtask
	// Pulses are seen two edges after the write edge and last one cycle.
	task automatic pulse(input logic [4:0] e);
		@(negedge clk);
		chk("cmd", {11'h000, e}, {11'h000, cmd_v});
		@(negedge clk);
		chk("cmd idle", 16'h0000, {11'h000, cmd_v});
	endtask
	task automatic set_st(input logic [7:0] v, input logic [1:0] s, input logic [15:0] b);
		{net_error, speed_arrived, dc_braking, stopping, brake_open, fwd_run_active,
			rev_run_active, remote_speed_source} = v;
		{cmd_source, base_status} = {s, b};
	endtask
	task automatic set_tr(input logic [8:0] v, input logic [4:0] b);
		{earth_leak_trip, drive_heatsink_trip, motor_thermal_trip, load_excess_trip,
			hardware_diagnostic_trip, second_current_trip, plugin_board_error,
			input_phase_loss, inverter_load_trip} = v;
		base_trips = b;
	endtask
	task automatic t_cmd;
		for (int i = 0; i < 5; i++) begin
			io(1'b1, 16'h0006, 16'h0001 << i, 1'b0);
			pulse(5'h01 << i);
			io(1'b1, 16'h0006, 16'h0001 << i, 1'b0);
			pulse(5'h00);
			io(1'b1, 16'h0006, 16'h0000, 1'b0);
			pulse(5'h00);
		end
	endtask
	task automatic t_status;
		@(negedge clk);
		set_st(8'hD5, 2'h2, 16'h002A);
		io(1'b1, 16'h0006, 16'hFF13, 1'b0);
		pulse(5'h13);
		rd(16'h000E, 16'h696A);
		rd(16'h0006, 16'h8093);
		set_st(8'h2A, 2'h1, 16'h0000);
		repeat (3) @(negedge clk);
		rd(16'h000E, 16'h1480);
		rd(16'h0006, 16'h0053);
		// The serial port source must count as remote as well as the option card.
		set_st(8'h00, 2'h3, 16'h0015);
		repeat (3) @(negedge clk);
		rd(16'h000E, 16'h2015);
		rd(16'h0006, 16'h00D3);
		set_st(8'h00, 2'h0, 16'h0000);
		repeat (3) @(negedge clk);
		rd(16'h000E, 16'h0000);
		rd(16'h0006, 16'h0013);
	endtask
	task automatic t_trip;
		set_tr(9'h124, 5'h15);
		repeat (3) @(negedge clk);
		rd(16'h000F, 16'h2155);
		io(1'b1, 16'h000F, 16'hFFFF, 1'b0);
		pulse(5'h00);
		rd(16'h000F, 16'h2155);
		set_tr(9'h0DB, 5'h0A);
		repeat (3) @(negedge clk);
		rd(16'h000F, 16'hD4CA);
	endtask
	// Addresses 0x16 to 0x19 sit in the gap and must be refused.
	task automatic t_words;
		for (int a = 16; a < 29; a++) begin
			io(1'b0, 16'(a), 16'h0000, a > 21 && a < 26);
			chk("word", (a > 21 && a < 26) ? 16'h0000 : 16'hA000 | 16'(a), m.rdata_s);
		end
		io(1'b1, 16'h0007, 16'h0001, 1'b1);
		io(1'b1, 16'h0015, 16'h0000, 1'b0);
		rd(16'h0015, 16'hA015);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		set_st(8'h00, 2'h0, 16'h0000);
		set_tr(9'h000, 5'h00);
		{input_terminal_states, output_terminal_states} = {16'hA010, 16'hA011};
		{analog_voltage_in_one, analog_voltage_in_two} = {16'hA012, 16'hA013};
		{analog_current_in, shaft_speed} = {16'hA014, 16'hA015};
		{display_unit_select, motor_pole_count} = {16'hA01A, 16'hA01B};
		custom_build_version = 16'hA01C;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		t_cmd();
		t_status();
		t_trip();
		t_words();
		close_out();
	end
	initial begin
		#5000;
		bad_count++;
		close_out();
	end
endmodule // dscr_regs_tb
